// File: stop_mode_params.svh
// Constants for the stop-mode selection and exit controller
`ifndef STOP_MODE_PARAMS_SVH
`define STOP_MODE_PARAMS_SVH

// Clock period in ns (100 MHz core clock)
`define SMS_CLK_PERIOD_NS      10
// Number of wake-up interrupt sources
`define SMS_WAKE_SRC_NUM       6
// Bit positions of the wake-up sources
`define SMS_WAKE_RTC           0
`define SMS_WAKE_LOWVOLT       1
`define SMS_WAKE_COMPARATOR    2
`define SMS_WAKE_ADC           3
`define SMS_WAKE_SERIAL        4
`define SMS_WAKE_PIN           5
// Reset values of the control bits
`define SMS_STOP_ALLOW_RST     1'b0
`define SMS_DEBUG_ALLOW_RST    1'b0
// Reset request pulse length minus one, in cycles
`define SMS_RESET_PULSE_CYC    4'h4

`endif

// File: stop_mode_pkg.sv
// Types for the stop-mode selection and exit controller
package stop_mode_pkg;

  // Outcome of a stop instruction
  typedef enum logic [2:0]
  {
    MODE_NONE        = 3'h0,
    MODE_ILLEGAL     = 3'h1,
    MODE_RET_DEBUG   = 3'h2,
    MODE_RET_REGUL   = 3'h3,
    MODE_RET_PLAIN   = 3'h4,
    MODE_PARTIAL_PD  = 3'h5
  } stop_outcome_type;

  // Controller states
  typedef enum logic [2:0]
  {
    ST_RUN           = 3'h0,
    ST_RETAINED      = 3'h1,
    ST_PARTIAL       = 3'h2,
    ST_RESET_REQ     = 3'h3,
    ST_WAKE_IRQ      = 3'h4
  } sms_state_type;

  // Configuration bits gathered as one carrier
  typedef struct packed
  {
    logic stop_instruction_allow;
    logic debug_mode_allow;
    logic lowvolt_detect_on;
    logic lowvolt_detect_in_stop;
    logic partial_powerdown_select;
  } stop_cfg_type;

  // Power controls held during stop
  typedef struct packed
  {
    logic debug_clk_on;
    logic regulator_full;
    logic adc_run_ok;
    logic cmp_bg_ok;
    logic hold_state;
  } stop_ctrl_type;

endpackage

// File: stop_mode_decode.sv
// Combinational decoder from control bits to stop outcome
`timescale 1ns/1ns
`default_nettype none
module stop_mode_decode
  import stop_mode_pkg::*;
(
  input  wire stop_cfg_type     i_cfg,
  output var  stop_outcome_type o_outcome
);

  ////////////////////////////////////////////////////////////////////////
  // Priority: stop allow, then debug, then low-voltage pair, then select
  always_comb
  begin
    if (!i_cfg.stop_instruction_allow)
      o_outcome = MODE_ILLEGAL;
    else if (i_cfg.debug_mode_allow)
      o_outcome = MODE_RET_DEBUG;
    else if (i_cfg.lowvolt_detect_on && i_cfg.lowvolt_detect_in_stop)
      o_outcome = MODE_RET_REGUL;
    else if (i_cfg.partial_powerdown_select)
      o_outcome = MODE_PARTIAL_PD;
    else
      o_outcome = MODE_RET_PLAIN;
  end

endmodule // stop_mode_decode
`default_nettype wire

// File: stop_mode_select.sv
// Stop-mode selection, entry and exit controller
//
// Contract
// - Stop disallowed: stop instruction causes reset
// - Debug allowed: retained stop with debug
// - Both low-voltage bits: retained, regulator on
// - Otherwise select picks retained or partial
// - Mode entered only on stop instruction
// - Retained stop holds all state unchanged
// - Exit by reset pin, or by wake interrupts from retained stop only
// - Reset pin exit gives full reset
// - Interrupt exit takes its vector, no reset
// - Converter runs in stop only if detector on
// - Comparator bandgap only if detector on
// - Debug entry from run needs debug allow
// - Debug allow keeps debug clocks in stop
// - Debug allow keeps regulator fully on
// - Debug allow written only by debug commands
`timescale 1ns/1ns
`default_nettype none
`include "stop_mode_params.svh"
module stop_mode_select
  import stop_mode_pkg::*;
#(
  parameter int WAKE_NUM = `SMS_WAKE_SRC_NUM
)
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rstn,
  input  wire logic                i_stop_exec,
  input  wire logic                i_stop_instruction_allow,
  input  wire logic                i_dbg_cmd_wr,
  input  wire logic                i_dbg_cmd_allow,
  input  wire logic                i_lowvolt_detect_on,
  input  wire logic                i_lowvolt_detect_in_stop,
  input  wire logic                i_partial_powerdown_select,
  input  wire logic                i_reset_pin_n,
  input  wire logic [WAKE_NUM-1:0] i_wake_irq,
  input  wire logic                i_bkgd_req,
  output var  logic                o_reset_req,
  output var  logic                o_wake_irq,
  output var  logic [WAKE_NUM-1:0] o_wake_src,
  output var  logic                o_in_retained,
  output var  logic                o_in_partial,
  output var  logic                o_bkgd_enter,
  output var  logic                o_debug_mode_allow,
  output var  stop_ctrl_type       o_stop_ctrl
);

  // Elaboration check: wake vector must cover the listed sources
  if (WAKE_NUM < `SMS_WAKE_SRC_NUM)
  begin : g_bad_wake
    $error("WAKE_NUM too small for listed wake sources");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  sms_state_type    state_ff, nxt_state;       // Controller state
  stop_outcome_type outcome;                   // Decoded stop outcome
  stop_cfg_type     cfg;                       // Live configuration
  stop_ctrl_type    ctrl_ff, nxt_ctrl;         // Controls held in stop
  logic             dbg_allow_ff, nxt_dbg_allow;   // Debug allow bit
  logic [3:0]       rst_cnt_ff, nxt_rst_cnt;   // Reset pulse counter
  logic             rst_req_ff, nxt_rst_req;   // Reset request
  logic             irq_ff, nxt_irq;           // Wake interrupt pulse
  logic [WAKE_NUM-1:0] src_ff, nxt_src;        // Waking source(s)
  logic             bkgd_ff, nxt_bkgd;         // Background entry pulse
  logic             in_ret_ff, in_part_ff;     // Mode flags
  default clocking chk_cb @(posedge i_ref_clk); // Checks on core clock
  endclocking
  default disable iff (!i_rstn);               // Checks quiet in reset

  // Any listed wake source pending
  function automatic logic any_wake(input logic [WAKE_NUM-1:0] v);
    any_wake = |v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration carrier and outcome decode
  always_comb
  begin
    cfg.stop_instruction_allow   = i_stop_instruction_allow;
    cfg.debug_mode_allow         = dbg_allow_ff;
    cfg.lowvolt_detect_on        = i_lowvolt_detect_on;
    cfg.lowvolt_detect_in_stop   = i_lowvolt_detect_in_stop;
    cfg.partial_powerdown_select = i_partial_powerdown_select;
  end

  stop_mode_decode u_decode
  (
    .i_cfg     (cfg),
    .o_outcome (outcome)
  );

  ////////////////////////////////////////////////////////////////////////
  // Debug allow bit: only the debug command port can change it,
  // so program code has no path to it
  always_comb
  begin
    nxt_dbg_allow = dbg_allow_ff;
    if (i_dbg_cmd_wr)
      nxt_dbg_allow = i_dbg_cmd_allow;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      dbg_allow_ff <= `SMS_DEBUG_ALLOW_RST;
    else
      dbg_allow_ff <= nxt_dbg_allow;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequencer: entry, hold and exit
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_rst_req = 1'b0;
    nxt_irq     = 1'b0;
    nxt_src     = src_ff;
    nxt_bkgd    = 1'b0;
    case (state_ff)
      ST_RUN:
      begin
        // Background entry from run is gated by the allow bit
        nxt_bkgd = i_bkgd_req && dbg_allow_ff;
        nxt_ctrl = '0;
        // Only the stop instruction starts a transition
        if (i_stop_exec)
        begin
          case (outcome)
            MODE_ILLEGAL:
            begin
              nxt_state   = ST_RESET_REQ;
              nxt_rst_cnt = `SMS_RESET_PULSE_CYC;
              nxt_rst_req = 1'b1;
            end
            MODE_PARTIAL_PD:
              nxt_state = ST_PARTIAL;
            MODE_RET_DEBUG, MODE_RET_REGUL, MODE_RET_PLAIN:
            begin
              nxt_state = ST_RETAINED;
              nxt_ctrl.hold_state     = 1'b1;
              nxt_ctrl.debug_clk_on   = (outcome == MODE_RET_DEBUG);
              nxt_ctrl.regulator_full = (outcome == MODE_RET_DEBUG)
                                     || (outcome == MODE_RET_REGUL);
              // Analog blocks may run only if detector was on at entry
              nxt_ctrl.adc_run_ok = (outcome == MODE_RET_REGUL);
              nxt_ctrl.cmp_bg_ok = (outcome == MODE_RET_REGUL);
            end
            default:
              nxt_state = ST_RUN;
          endcase
        end
      end
      ST_RETAINED:
      begin
        // Controls frozen; reset pin wins over interrupts
        if (!i_reset_pin_n)
        begin
          nxt_state   = ST_RESET_REQ;
          nxt_rst_cnt = `SMS_RESET_PULSE_CYC;
          nxt_rst_req = 1'b1;
          nxt_ctrl    = '0;
        end
        else if (any_wake(i_wake_irq))
        begin
          nxt_state = ST_WAKE_IRQ;
          nxt_irq   = 1'b1;
          nxt_src   = i_wake_irq;
          nxt_ctrl  = '0;
        end
      end
      ST_PARTIAL:
      begin
        // Partial power-down leaves only through the reset pin
        if (!i_reset_pin_n)
        begin
          nxt_state   = ST_RESET_REQ;
          nxt_rst_cnt = `SMS_RESET_PULSE_CYC;
          nxt_rst_req = 1'b1;
        end
      end
      ST_RESET_REQ:
      begin
        // Hold reset for the pulse length, then while pin held
        nxt_rst_req = 1'b1;
        if (rst_cnt_ff != 4'h0)
          nxt_rst_cnt = rst_cnt_ff - 4'h1;
        else if (i_reset_pin_n)
        begin
          nxt_rst_req = 1'b0;
          nxt_state   = ST_RUN;
        end
      end
      ST_WAKE_IRQ:
        nxt_state = ST_RUN;
      default:
        nxt_state = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff   <= ST_RUN;
      ctrl_ff    <= '0;
      rst_cnt_ff <= 4'h0;
      rst_req_ff <= 1'b0;
      irq_ff     <= 1'b0;
      src_ff     <= '0;
      bkgd_ff    <= 1'b0;
      in_ret_ff  <= 1'b0;
      in_part_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      ctrl_ff    <= nxt_ctrl;
      rst_cnt_ff <= nxt_rst_cnt;
      rst_req_ff <= nxt_rst_req;
      irq_ff     <= nxt_irq;
      src_ff     <= nxt_src;
      bkgd_ff    <= nxt_bkgd;
      in_ret_ff  <= (nxt_state == ST_RETAINED);
      in_part_ff <= (nxt_state == ST_PARTIAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  always_comb
  begin
    o_reset_req        = rst_req_ff;
    o_wake_irq         = irq_ff;
    o_wake_src         = src_ff;
    o_in_retained      = in_ret_ff;
    o_in_partial       = in_part_ff;
    o_bkgd_enter       = bkgd_ff;
    o_debug_mode_allow = dbg_allow_ff;
    o_stop_ctrl        = ctrl_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_ILLEGAL_RESET: assert property (
    (state_ff == ST_RUN && i_stop_exec && !i_stop_instruction_allow)
    |=> o_reset_req && !o_in_retained && !o_in_partial)
    else $error("Disallowed stop did not reset");
  AST_DEBUG_ENTRY: assert property (
    (state_ff == ST_RUN && i_stop_exec && i_stop_instruction_allow
     && dbg_allow_ff) |=> o_in_retained && o_stop_ctrl.debug_clk_on)
    else $error("Debug stop not retained with debug clocks");
  AST_REGUL_ENTRY: assert property (
    (state_ff == ST_RUN && i_stop_exec && i_stop_instruction_allow
     && !dbg_allow_ff && i_lowvolt_detect_on && i_lowvolt_detect_in_stop)
    |=> o_in_retained && o_stop_ctrl.regulator_full)
    else $error("Regulator not kept on");
  AST_SELECT: assert property (
    (state_ff == ST_RUN && i_stop_exec && i_stop_instruction_allow
     && !dbg_allow_ff && !(i_lowvolt_detect_on && i_lowvolt_detect_in_stop))
    |=> (o_in_partial == $past(i_partial_powerdown_select))
        && (o_in_retained != $past(i_partial_powerdown_select)))
    else $error("Power-down select misapplied");
  AST_NO_SPONT: assert property (
    (state_ff == ST_RUN && !i_stop_exec) |=> !o_in_retained && !o_in_partial)
    else $error("Stop entered without instruction");
  AST_HOLD: assert property (
    (state_ff == ST_RETAINED && $past(state_ff) == ST_RETAINED)
    |-> $stable(ctrl_ff) && $stable(src_ff))
    else $error("State changed during retained stop");
  AST_PIN_EXIT: assert property (
    (state_ff == ST_RETAINED && !i_reset_pin_n)
    |=> o_reset_req && !o_wake_irq ##1 o_reset_req)
    else $error("Reset pin exit without reset");
  AST_IRQ_EXIT: assert property (
    (state_ff == ST_RETAINED && i_reset_pin_n && (|i_wake_irq))
    |=> o_wake_irq && !o_reset_req && o_wake_src == $past(i_wake_irq))
    else $error("Interrupt exit wrong");
  AST_ANALOG: assert property (
    (o_stop_ctrl.adc_run_ok || o_stop_ctrl.cmp_bg_ok)
    |-> o_in_retained && o_stop_ctrl.regulator_full)
    else $error("Analog run without detector");
  AST_BKGD: assert property (
    o_bkgd_enter |-> $past(dbg_allow_ff) && $past(i_bkgd_req))
    else $error("Background entry without allow");
  AST_DBG_REG: assert property (
    o_stop_ctrl.debug_clk_on |-> o_stop_ctrl.regulator_full)
    else $error("Debug stop without full regulation");
  AST_DBG_WR: assert property (
    !$past(i_dbg_cmd_wr) |-> $stable(dbg_allow_ff))
    else $error("Debug allow changed without command");

endmodule // stop_mode_select
`default_nettype wire

// File: core_model.sv
// Core and wake-source model driving the stop controller inputs
`timescale 1ns/1ns
`default_nettype none
module core_model
#(
  parameter int WAKE_NUM = 6
)
(
  input  wire logic                i_ref_clk,
  output var  logic                o_stop_exec,
  output var  logic [WAKE_NUM-1:0] o_wake_irq,
  output var  logic                o_reset_pin_n,
  output var  logic                o_dbg_cmd_wr,
  output var  logic                o_dbg_cmd_allow
);
  ////////////////////////////////////////////////////////////////////////
  // Idle levels: no stop, no wake, pin released
  initial
  begin
    o_stop_exec     = 1'b0;
    o_wake_irq      = '0;
    o_reset_pin_n   = 1'b1;
    o_dbg_cmd_wr    = 1'b0;
    o_dbg_cmd_allow = 1'b1;
  end

  // Every change lands off the sampling edge
  task automatic step();
    @(negedge i_ref_clk);
  endtask

  // Stop instruction retires as a one-cycle pulse
  task automatic stop_pulse();
    step();
    o_stop_exec = 1'b1;
    step();
    o_stop_exec = 1'b0;
  endtask

  // Wake level held for one edge only
  task automatic wake(input logic [WAKE_NUM-1:0] src);
    step();
    o_wake_irq = src;
    step();
    o_wake_irq = '0;
  endtask

  // Allow bit moves only through a debug command strobe
  task automatic dbg_write(input logic v);
    step();
    o_dbg_cmd_wr    = 1'b1;
    o_dbg_cmd_allow = v;
    step();
    o_dbg_cmd_wr    = 1'b0;
    // Data no longer qualified: show the inverse, not a stale copy
    o_dbg_cmd_allow = ~v;
  endtask
endmodule // core_model
`default_nettype wire

// File: stop_mode_select_tb.sv
// Self-checking bench for the stop-mode controller
`timescale 1ns/1ns
`default_nettype none
module stop_mode_select_tb
  import stop_mode_pkg::*;
();
  localparam int WN = 6;
  logic          clk;        // Core clock
  logic          rstn;       // Async reset, low active
  logic          bkgd_req;   // Background entry request
  stop_cfg_type  cfg;        // Configuration levels
  logic          stop_exec, wr, wval, pin_n;
  logic [WN-1:0] wake, wake_src;
  logic          reset_req, wake_pulse, in_ret, in_par;
  logic          bkgd_enter, dbg_allow;
  stop_ctrl_type ctrl;       // Power controls seen
  int            num_errors, total_checks, i;
  logic [31:0]   seed, r;

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  stop_mode_select #(.WAKE_NUM(WN)) stop_mode_select_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_stop_exec(stop_exec),
    .i_stop_instruction_allow(cfg.stop_instruction_allow),
    .i_dbg_cmd_wr(wr), .i_dbg_cmd_allow(wval),
    .i_lowvolt_detect_on(cfg.lowvolt_detect_on),
    .i_lowvolt_detect_in_stop(cfg.lowvolt_detect_in_stop),
    .i_partial_powerdown_select(cfg.partial_powerdown_select),
    .i_reset_pin_n(pin_n), .i_wake_irq(wake), .i_bkgd_req(bkgd_req),
    .o_reset_req(reset_req), .o_wake_irq(wake_pulse),
    .o_wake_src(wake_src), .o_in_retained(in_ret),
    .o_in_partial(in_par), .o_bkgd_enter(bkgd_enter),
    .o_debug_mode_allow(dbg_allow), .o_stop_ctrl(ctrl));

  core_model #(.WAKE_NUM(WN)) core_model_i (
    .i_ref_clk(clk), .o_stop_exec(stop_exec), .o_wake_irq(wake),
    .o_reset_pin_n(pin_n), .o_dbg_cmd_wr(wr), .o_dbg_cmd_allow(wval));

  ////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source
  function automatic void nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r = seed;
  endfunction

  // Outcome code: 4 reset, 2 partial, 1 retained
  function automatic logic [2:0] exp_mode(input stop_cfg_type c);
    if (!c.stop_instruction_allow) return 3'h4;
    if (c.debug_mode_allow) return 3'h1;
    if (c.lowvolt_detect_on && c.lowvolt_detect_in_stop) return 3'h1;
    return c.partial_powerdown_select ? 3'h2 : 3'h1;
  endfunction

  // Controls expected while retained
  function automatic stop_ctrl_type exp_ctrl(input stop_cfg_type c);
    exp_ctrl = '0;
    exp_ctrl.hold_state = 1'b1;
    if (c.debug_mode_allow)
    begin
      exp_ctrl.debug_clk_on   = 1'b1;
      exp_ctrl.regulator_full = 1'b1;
    end
    else if (c.lowvolt_detect_on && c.lowvolt_detect_in_stop)
    begin
      exp_ctrl.regulator_full = 1'b1;
      exp_ctrl.adc_run_ok     = 1'b1;
      exp_ctrl.cmp_bg_ok      = 1'b1;
    end
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic step();
    @(negedge clk);
  endtask

  task automatic set_dbg(input logic v);
    core_model_i.dbg_write(v);
    check(dbg_allow, v);
  endtask

  // Pin exit; reset request must rise with the pin low and clear after the pin is released
  task automatic pin_exit();
    int n;
    step();
    pin_n = 1'b0;
    step();
    check({reset_req, in_ret, in_par}, 3'h4);
    repeat (5) step();
    pin_n = 1'b1;
    n = 0;
    while (reset_req === 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    check(reset_req, 1'b0);
  endtask

  // One stop instruction under a given configuration
  task automatic run_stop(input stop_cfg_type c);
    logic [2:0] m;
    stop_ctrl_type held;
    logic [WN-1:0] src;
    int n;
    set_dbg(c.debug_mode_allow);
    cfg = c;
    step();
    check({in_ret, in_par, reset_req}, 3'h0);
    core_model_i.stop_pulse();
    m = exp_mode(c);
    check({reset_req, in_par, in_ret}, m);
    if (m == 3'h4)
    begin
      n = 1;
      step();
      while (reset_req === 1'b1 && n < 20)
      begin
        n++;
        step();
      end
      check(n[7:0], 8'h05);
    end
    else if (m == 3'h1)
    begin
      check(ctrl, exp_ctrl(c));
      held = ctrl;
      nxt();
      cfg = r[4:0];
      repeat (2) step();
      check({in_ret, ctrl}, {1'b1, held});
      nxt();
      src = (r[5:0] == 6'h00) ? 6'h01 : r[5:0];
      if (r[8])
        pin_exit();
      else
      begin
        core_model_i.wake(src);
        check({wake_pulse, wake_src}, {1'b1, src});
        check({reset_req, in_ret, ctrl}, 7'h00);
        step();
        check(wake_pulse, 1'b0);
      end
    end
    else
    begin
      check(ctrl, 5'h00);
      core_model_i.wake(6'h3f);
      check({in_par, wake_pulse}, 2'h2);
      pin_exit();
    end
    repeat (2) step();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Corner table first, then random configurations
  logic [4:0] tbl [6] = '{5'h00, 5'h18, 5'h1f, 5'h16, 5'h10, 5'h11};

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    cfg = '0;
    bkgd_req = 1'b0;
    seed = 32'haaee3e97;
    num_errors = 0;
    total_checks = 0;
    repeat (2) step();
    rstn = 1'b1;
    check({reset_req, wake_pulse, in_ret, in_par, dbg_allow}, 5'h00);
    for (i = 0; i < 2; i++)
    begin
      set_dbg(i[0]);
      bkgd_req = 1'b1;
      step();
      bkgd_req = 1'b0;
      check(bkgd_enter, i[0]);
    end
    for (i = 0; i < 6; i++) run_stop(tbl[i]);
    for (i = 0; i < 24; i++)
    begin
      nxt();
      run_stop(r[4:0] | {r[5], 4'h0});
    end
    // Mid-run reset clears the allow bit again
    set_dbg(1'b1);
    rstn = 1'b0;
    step();
    check({dbg_allow, in_ret, reset_req}, 3'h0);
    rstn = 1'b1;
    // Work on after the release; allow bit stays clear without a command
    step();
    check({dbg_allow, wake_pulse, in_ret, reset_req}, 4'h0);
    run_stop(5'h16);
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #100000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // stop_mode_select_tb
`default_nettype wire
